// [pkg/fpls_pkg.sv]
// Constants, codes and types shared by the flash command sequencer host.
// Assumes a byte-wide flash with a two-cycle command interface and status byte.
package fpls_pkg;

  // ****************************************************************
  // Flash command codes
  // ****************************************************************
  localparam logic [7:0] CODE_READ_ARRAY = 8'hff;
  localparam logic [7:0] CODE_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CODE_CONFIRM = 8'hd0;
  localparam logic [7:0] CODE_WRITE_SETUP = 8'h40;
  localparam logic [7:0] CODE_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CODE_LOCK_BLOCK = 8'h01;
  localparam logic [7:0] CODE_LOCK_MASTER = 8'hf1;
  localparam logic [7:0] CODE_CLEAR_STATUS = 8'h50;

  // ****************************************************************
  // Flash status byte fields
  // ****************************************************************
  localparam int SR_MACHINE_READY = 7;
  localparam int SR_ERASE_FAIL = 5;
  localparam int SR_PROGRAM_FAIL = 4;
  localparam logic [7:0] SR_ERROR_MASK = 8'h3a;

  // ****************************************************************
  // Own register map (byte offsets) and status word fields
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  localparam int ST_ACCUM_LSB = 8;
  localparam int ST_BUSY = 16;
  localparam int ST_SEQ_ERR = 17;
  localparam int ST_READY_PIN = 18;
  localparam int ST_POWER_OK = 19;
  localparam int ST_ABORT = 20;
  localparam int ST_DONE = 21;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int BUS_PHASE_NS = 60;
  localparam logic [7:0] PHASE_CYC = 8'((BUS_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ****************************************************************
  // Operations and sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_READ_ARRAY = 3'b000,
    OP_ERASE = 3'b001,
    OP_PROGRAM = 3'b010,
    OP_LOCK_BLOCK = 3'b011,
    OP_LOCK_MASTER = 3'b100,
    OP_CLEAR_LOCKS = 3'b101,
    OP_CLEAR_STATUS = 3'b110,
    OP_READ_BYTE = 3'b111
  } fpls_op_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_WR = 3'b001,
    S_WREC = 3'b010,
    S_RD = 3'b011,
    S_RREC = 3'b100
  } fpls_state_t;

endpackage

// [hdl/fpls_sync.sv]
// Three-stage synchroniser for pin inputs, one chain per bit.
// Assumes inputs are asynchronous to aclk; output moves when stages two and three agree.
module fpls_sync
  import fpls_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } fpls_sync_t;

  fpls_sync_t st_r;
  fpls_sync_t st_nxt;

  // Shift chain; output follows only an agreed value
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (st_r.s2[i] == st_r.s3[i])
      begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.q;

endmodule // fpls_sync

// [hdl/fpls_host.sv]
// Host-side sequencer driving a byte-wide flash through its pins, set up over AXI4-Lite.
// Assumes aclk at 250 MHz and a flash that shows its status byte after each confirm write.
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
module fpls_host
  import fpls_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [19:0] flash_addr,
  input wire logic [7:0] flash_dq_i,
  output logic [7:0] flash_dq_o,
  output logic flash_dq_oe,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic reset_powerdown_n,
  input wire logic ready_busy_n,
  input wire logic system_power_ok
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic pd_req;
    fpls_state_t st;
    fpls_op_t op;
    logic [1:0] step;
    logic [7:0] cnt;
    logic [19:0] addr;
    logic [7:0] wbyte;
    logic [7:0] dq;
    logic [7:0] stat;
    logic [7:0] accum;
    logic [7:0] rbyte;
    logic busy;
    logic done;
    logic abort;
    logic pin_rst_n;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic dq_oe;
  } fpls_host_t;

  fpls_host_t st_r;
  fpls_host_t st_nxt;
  logic [9:0] pins_sync;
  logic [7:0] dq_sync;
  logic rb_pin_sync;
  logic pok_sync;
  logic [31:0] rd_word;
  logic cmd_write;
  logic two_cycle;

  // Pin inputs pass the three-stage synchroniser
  fpls_sync #(.WIDTH(10)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({system_power_ok, ready_busy_n, flash_dq_i}),
    .dout(pins_sync)
  );
  assign dq_sync = pins_sync[7:0];
  assign rb_pin_sync = pins_sync[8];
  assign pok_sync = pins_sync[9];

  // First and second command byte of each operation
  function automatic logic [7:0] first_code(input fpls_op_t op);
    case (op)
      OP_ERASE: first_code = CODE_ERASE_SETUP;
      OP_PROGRAM: first_code = CODE_WRITE_SETUP;
      OP_LOCK_BLOCK, OP_LOCK_MASTER, OP_CLEAR_LOCKS: first_code = CODE_LOCK_SETUP;
      OP_CLEAR_STATUS: first_code = CODE_CLEAR_STATUS;
      default: first_code = CODE_READ_ARRAY;
    endcase
  endfunction

  function automatic logic [7:0] second_code(input fpls_op_t op, input logic [7:0] wbyte);
    case (op)
      OP_PROGRAM: second_code = wbyte;
      OP_LOCK_BLOCK: second_code = CODE_LOCK_BLOCK;
      OP_LOCK_MASTER: second_code = CODE_LOCK_MASTER;
      default: second_code = CODE_CONFIRM;
    endcase
  endfunction

  // Status word seen by software
  always_comb
  begin
    rd_word = '0;
    rd_word[7:0] = st_r.stat & ~8'h01;
    rd_word[ST_ACCUM_LSB +: 8] = st_r.accum;
    rd_word[ST_BUSY] = st_r.busy;
    rd_word[ST_SEQ_ERR] = st_r.accum[SR_ERASE_FAIL] & st_r.accum[SR_PROGRAM_FAIL];
    rd_word[ST_READY_PIN] = rb_pin_sync;
    rd_word[ST_POWER_OK] = pok_sync;
    rd_word[ST_ABORT] = st_r.abort;
    rd_word[ST_DONE] = st_r.done;
  end

  assign cmd_write = st_r.aw_have && st_r.w_have && !st_r.bvalid && st_r.w_lane0 && (st_r.aw_addr == REG_CMD);
  assign two_cycle = (st_r.op != OP_READ_ARRAY) && (st_r.op != OP_CLEAR_STATUS) && (st_r.op != OP_READ_BYTE);

  // ****************************************************************
  // Next state: bus slave and flash sequencer
  // ****************************************************************
  always_comb
  begin
    st_nxt = st_r;
    // Address and data channels are taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      st_nxt.w_have = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      st_nxt.bvalid = 1'b0;
    end
    // Register write once both halves are in
    if (st_r.aw_have && st_r.w_have && !st_r.bvalid)
    begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      case (st_r.aw_addr)
        REG_CTRL: if (st_r.w_lane0) st_nxt.pd_req = st_r.w_data[0];
        REG_CMD: ;
        REG_ADDR: if (st_r.w_lane0) st_nxt.addr = st_r.w_data[19:0];
        REG_DATA: if (st_r.w_lane0) st_nxt.wbyte = st_r.w_data[7:0];
        REG_STATUS, REG_RDATA: ;
        default: st_nxt.bresp = RESP_SLVERR;
      endcase
    end
    // Read channel
    if (s_axi_rvalid && s_axi_rready)
    begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL: st_nxt.rdata = {31'h0, st_r.pd_req};
        REG_CMD: st_nxt.rdata = {29'h0, st_r.op};
        REG_ADDR: st_nxt.rdata = {12'h000, st_r.addr};
        REG_DATA: st_nxt.rdata = {24'h000000, st_r.wbyte};
        REG_STATUS: st_nxt.rdata = rd_word;
        REG_RDATA: st_nxt.rdata = {24'h000000, st_r.rbyte};
        default:
        begin
          st_nxt.rdata = '0;
          st_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
    // Reset pin held low unless power is good and no power-down asked
    st_nxt.pin_rst_n = pok_sync && !st_nxt.pd_req;
    if (st_r.cnt != 8'h00)
    begin
      st_nxt.cnt = st_r.cnt - 8'h01;
    end
    case (st_r.st)
      S_IDLE:
      begin
        // Commands are taken only while idle, so the next op waits on the poll
        if (cmd_write && st_r.pin_rst_n)
        begin
          st_nxt.op = fpls_op_t'(st_r.w_data[2:0]);
          st_nxt.step = 2'd0;
          st_nxt.busy = 1'b1;
          st_nxt.done = 1'b0;
          st_nxt.abort = 1'b0;
          st_nxt.cnt = PHASE_CYC - 8'h01;
          st_nxt.dq = first_code(fpls_op_t'(st_r.w_data[2:0]));
          st_nxt.st = (fpls_op_t'(st_r.w_data[2:0]) == OP_READ_BYTE) ? S_RD : S_WR;
          if (fpls_op_t'(st_r.w_data[2:0]) == OP_CLEAR_STATUS)
          begin
            st_nxt.accum = 8'h00;
          end
        end
      end
      S_WR:
      begin
        if (st_r.cnt == 8'h00)
        begin
          st_nxt.st = S_WREC;
          st_nxt.cnt = PHASE_CYC - 8'h01;
        end
      end
      S_WREC:
      begin
        if (st_r.cnt == 8'h00)
        begin
          st_nxt.cnt = PHASE_CYC - 8'h01;
          if (st_r.step == 2'd0 && two_cycle)
          begin
            st_nxt.step = 2'd1;
            st_nxt.dq = second_code(st_r.op, st_r.wbyte);
            st_nxt.st = S_WR;
          end
          else if (st_r.step == 2'd1)
          begin
            st_nxt.st = S_RD;
          end
          else
          begin
            st_nxt.st = S_IDLE;
            st_nxt.busy = 1'b0;
            st_nxt.done = 1'b1;
          end
        end
      end
      S_RD:
      begin
        if (st_r.cnt == 8'h00)
        begin
          st_nxt.st = S_RREC;
          st_nxt.cnt = PHASE_CYC - 8'h01;
          if (st_r.op == OP_READ_BYTE)
          begin
            st_nxt.rbyte = dq_sync;
          end
          else
          begin
            st_nxt.stat = dq_sync;
          end
        end
      end
      S_RREC:
      begin
        if (st_r.cnt == 8'h00)
        begin
          st_nxt.cnt = PHASE_CYC - 8'h01;
          if (st_r.op == OP_READ_BYTE)
          begin
            st_nxt.st = S_IDLE;
            st_nxt.busy = 1'b0;
            st_nxt.done = 1'b1;
          end
          else if (st_r.stat[SR_MACHINE_READY])
          begin
            st_nxt.accum = st_r.accum | (st_r.stat & SR_ERROR_MASK);
            st_nxt.step = 2'd2;
            st_nxt.dq = CODE_READ_ARRAY;
            st_nxt.st = S_WR;
          end
          else
          begin
            st_nxt.st = S_RD;
          end
        end
      end
      default: st_nxt.st = S_IDLE;
    endcase
    // Losing the reset pin ends any sequence in progress
    if (!st_nxt.pin_rst_n && st_r.st != S_IDLE)
    begin
      st_nxt.st = S_IDLE;
      st_nxt.busy = 1'b0;
      st_nxt.abort = 1'b1;
    end
    st_nxt.ce_n = !(st_nxt.st == S_WR || st_nxt.st == S_RD);
    st_nxt.we_n = !(st_nxt.st == S_WR);
    st_nxt.oe_n = !(st_nxt.st == S_RD);
    st_nxt.dq_oe = (st_nxt.st == S_WR || st_nxt.st == S_WREC);
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // Strobes are active low, so reset leaves them released
      st_r <= '0;
      st_r.ce_n <= 1'b1;
      st_r.we_n <= 1'b1;
      st_r.oe_n <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready = !st_r.aw_have && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_have && !st_r.bvalid;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign flash_addr = st_r.addr;
  assign flash_dq_o = st_r.dq;
  assign flash_dq_oe = st_r.dq_oe;
  assign flash_ce_n = st_r.ce_n;
  assign flash_we_n = st_r.we_n;
  assign flash_oe_n = st_r.oe_n;
  assign reset_powerdown_n = st_r.pin_rst_n;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_erase_codes: assert property ((st_r.st == S_WR && st_r.op == OP_ERASE && st_r.step != 2'd2)
    |-> st_r.dq == ((st_r.step == 2'd0) ? CODE_ERASE_SETUP : CODE_CONFIRM)) else $error("erase code");
  a_program_codes: assert property ((st_r.st == S_WR && st_r.op == OP_PROGRAM && st_r.step != 2'd2)
    |-> st_r.dq == ((st_r.step == 2'd0) ? CODE_WRITE_SETUP : st_r.wbyte)) else $error("program code");
  a_lock_codes: assert property ((st_r.st == S_WR && st_r.op == OP_LOCK_MASTER && st_r.step == 2'd1)
    |-> st_r.dq == CODE_LOCK_MASTER && $past(st_r.dq, 2 * PHASE_CYC) == CODE_LOCK_SETUP)
    else $error("lock code");
  a_clear_lock_codes: assert property ((st_r.st == S_WR && st_r.op == OP_CLEAR_LOCKS && st_r.step == 2'd1)
    |-> st_r.dq == CODE_CONFIRM && $past(st_r.dq, 2 * PHASE_CYC) == CODE_LOCK_SETUP)
    else $error("clear lock code");
  a_read_array_after: assert property ((st_r.st == S_RREC && st_r.cnt == 8'h00 && st_r.op != OP_READ_BYTE
    && st_r.stat[SR_MACHINE_READY] && st_r.pin_rst_n && pok_sync && !st_r.pd_req)
    |=> st_r.st == S_WR && st_r.dq == CODE_READ_ARRAY && !flash_we_n) else $error("no read array");
  a_trailer_after_ready: assert property ((st_r.st == S_WR && st_r.step == 2'd2)
    |-> st_r.stat[SR_MACHINE_READY]) else $error("trailer before ready");
  a_busy_holds_op: assert property ((st_r.busy && cmd_write)
    |=> $stable(st_r.op) && $stable(st_r.step)) else $error("command taken while busy");
  a_poll_after_confirm: assert property ((st_r.st == S_WREC && st_r.step == 2'd1 && st_r.cnt == 8'h00
    && st_nxt.pin_rst_n) |=> !flash_oe_n && flash_we_n && !flash_dq_oe) else $error("no poll");
  a_reset_follows_power: assert property (!pok_sync |=> !reset_powerdown_n ##1 !st_r.busy)
    else $error("reset pin not low");
  a_strobes_apart: assert property (!(flash_we_n == 1'b0 && flash_oe_n == 1'b0))
    else $error("write and read strobes together");

  c_erase_done: cover property (st_r.op == OP_ERASE && $rose(st_r.done));
  c_program_done: cover property (st_r.op == OP_PROGRAM && $rose(st_r.done));
  c_lock_master: cover property (st_r.op == OP_LOCK_MASTER && $rose(st_r.done));
  c_abort: cover property ($rose(st_r.abort));

endmodule // fpls_host

// [tb/fpls_flash_model.sv]
// Behavioural model of the byte-wide flash that the host sequencer drives.
// Assumes strobes seen on aclk; vpp_bad puts a supply fault into erase, program, block lock and lock clear while high.
module fpls_flash_model
  import fpls_pkg::*;
(
  input wire logic aclk,
  input wire logic [19:0] addr,
  input wire logic [7:0] host_dq,
  input wire logic host_oe,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic pin_rst_n,
  input wire logic vpp_bad,
  input wire logic [15:0] busy_cyc,
  output logic [7:0] dq_bus = 8'h00,
  output logic ready_busy_n = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [int];
  logic [15:0] lock_r = '0;
  logic master_r = 1'b0; // Cannot be set with the reset pin at its normal level
  logic [7:0] sr_r = 8'h81;
  logic [7:0] setup_r = '0;
  logic stat_r = 1'b0;
  logic wr_prev = 1'b0;
  int busy_r = 0;
  // Decode of one finished write cycle
  task automatic take(input logic [7:0] d);
    logic [7:0] e;
    int b;
    e = '0;
    b = int'(addr[19:16]);
    if (setup_r == CODE_ERASE_SETUP)
    begin
      if (d != CODE_CONFIRM) e = 8'h30;
      else if (lock_r[b]) e = 8'h22;
      else if (vpp_bad) e = 8'h28;
      else foreach (mem[k]) if (k[19:16] == b) mem[k] = 8'hff;
    end
    else if (setup_r == CODE_WRITE_SETUP)
    begin
      if (lock_r[b]) e = 8'h12;
      else if (vpp_bad) e = 8'h18;
      else mem[int'(addr)] = d;
    end
    else if (setup_r == CODE_LOCK_SETUP)
    begin
      if (d == CODE_LOCK_MASTER || (d == CODE_LOCK_BLOCK && master_r)) e = 8'h12;
      else if (d == CODE_CONFIRM && master_r) e = 8'h22;
      else if (d != CODE_LOCK_BLOCK && d != CODE_CONFIRM) e = 8'h30;
      else if (vpp_bad) e = (d == CODE_CONFIRM) ? 8'h28 : 8'h18;
      else if (d == CODE_CONFIRM) lock_r = '0;
      else lock_r[b] = 1'b1;
    end
    if (setup_r != '0)
    begin
      sr_r = {1'b0, sr_r[6:0] | e[6:0]};
      busy_r = int'(busy_cyc);
      setup_r = '0;
    end
    else if (d == CODE_CLEAR_STATUS) sr_r = sr_r & 8'hc5;
    else if (d == CODE_READ_ARRAY) stat_r = 1'b0;
    else
    begin
      setup_r = d;
      stat_r = 1'b1;
    end
  endtask
  // Reset pin, busy count, write capture and bus drive
  always @(posedge aclk)
  begin
    if (!pin_rst_n)
    begin
      sr_r = 8'h81;
      busy_r = 0;
      setup_r = '0;
      stat_r = 1'b0;
    end
    else if (busy_r > 0)
    begin
      busy_r--;
      if (busy_r == 0) sr_r[7] = 1'b1;
    end
    else if (wr_prev && !(!ce_n && !we_n)) take(host_dq);
    wr_prev = !ce_n && !we_n;
    if (!ce_n && !oe_n) dq_bus <= stat_r ? sr_r : (mem.exists(int'(addr)) ? mem[int'(addr)] : 8'hff);
    else if (host_oe) dq_bus <= host_dq;
    else dq_bus <= ~dq_bus; // Released bus toggles between the last value and its complement
    ready_busy_n <= sr_r[7];
  end
endmodule // fpls_flash_model

// [tb/fpls_host_tb.sv]
// Testbench for the flash host sequencer: bus tasks, a table of operations, then awkward cases.
// Assumes the flash model beside it and a 250 MHz clock.
`define CHK(g, w) begin checks_done++; if ((g) !== (w)) begin error_cnt++; $display("ERROR %0t: %h vs %h", $time, g, w); end end
module fpls_host_tb
  import fpls_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] MP = 32'h0023_ffff;
  localparam logic [31:0] MI = 32'h0023_ff00;
  localparam logic [31:0] MR = 32'h0000_00ff;
  typedef struct {fpls_op_t o; logic [19:0] a; logic v; logic [31:0] m; logic [31:0] x;} fpls_row_t;
  logic aclk = 1'b0;
  logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, seen;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
  logic reset_powerdown_n, ready_busy_n, system_power_ok, vpp_bad;
  logic [7:0] s_axi_awaddr, s_axi_araddr, flash_dq_i, flash_dq_o;
  logic [31:0] s_axi_wdata, s_axi_rdata, st;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [19:0] flash_addr;
  logic [15:0] busy_cyc;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  fpls_row_t rows [15] = '{
    '{OP_PROGRAM, 20'h12345, 1'b0, MP, 32'h0020_0080},
    '{OP_READ_BYTE, 20'h12345, 1'b0, MR, 32'h0000_0045},
    '{OP_ERASE, 20'h12000, 1'b0, MP, 32'h0020_0080},
    '{OP_READ_BYTE, 20'h12345, 1'b0, MR, 32'h0000_00ff},
    '{OP_LOCK_BLOCK, 20'h30000, 1'b0, MP, 32'h0020_0080},
    '{OP_PROGRAM, 20'h30010, 1'b0, MP, 32'h0020_1292},
    '{OP_ERASE, 20'h30000, 1'b0, MP, 32'h0022_32b2},
    '{OP_CLEAR_STATUS, 20'h0, 1'b0, MI, 32'h0020_0000},
    '{OP_LOCK_MASTER, 20'h0, 1'b0, MP, 32'h0020_1292},
    '{OP_CLEAR_LOCKS, 20'h0, 1'b0, MP, 32'h0020_1292},
    '{OP_PROGRAM, 20'h30010, 1'b0, MP, 32'h0020_1292},
    '{OP_READ_BYTE, 20'h30010, 1'b0, MR, 32'h0000_0010},
    '{OP_CLEAR_STATUS, 20'h0, 1'b0, MI, 32'h0020_0000},
    '{OP_PROGRAM, 20'h40000, 1'b1, MP, 32'h0020_1898},
    '{OP_CLEAR_LOCKS, 20'h0, 1'b1, MP, 32'h0022_38b8}
  };
  fpls_host uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flash_addr, .flash_dq_i,
    .flash_dq_o, .flash_dq_oe, .flash_ce_n, .flash_we_n, .flash_oe_n, .reset_powerdown_n, .ready_busy_n,
    .system_power_ok);
  fpls_flash_model flash (.aclk, .addr(flash_addr), .host_dq(flash_dq_o), .host_oe(flash_dq_oe), .ce_n(flash_ce_n),
    .we_n(flash_we_n), .oe_n(flash_oe_n), .pin_rst_n(reset_powerdown_n), .vpp_bad, .busy_cyc, .dq_bus(flash_dq_i),
    .ready_busy_n);
  // Clock and hang guard
  always #2 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      $display("ERROR %0t: run did not finish", $time);
      summarize();
    end
  end
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Register write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ad, wd;
    ad = 0;
    wd = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (!ad && s_axi_awready)
      begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready)
      begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  // Register read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // One operation, then poll until the sequencer is idle
  task automatic op(input fpls_op_t o, input logic [19:0] a, output logic [31:0] s);
    wr(REG_ADDR, {12'h0, a}, rr);
    wr(REG_DATA, {24'h0, a[7:0]}, rr);
    wr(REG_CMD, {29'h0, o}, rr);
    do rd(REG_STATUS, s, rr); while (s[ST_BUSY]);
  endtask
  task automatic wait_up();
    do rd(REG_STATUS, st, rr); while (!st[ST_POWER_OK] || reset_powerdown_n !== 1'b1);
  endtask
  // Main sequence
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, vpp_bad, seen} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    system_power_ok = 1'b1;
    busy_cyc = 16'h0028;
    repeat (2) @(posedge aclk);
    `CHK(reset_powerdown_n, 1'b0)
    aresetn <= 1'b1;
    wait_up();
    foreach (rows[i])
    begin
      vpp_bad <= rows[i].v;
      op(rows[i].o, rows[i].a, st);
      if (rows[i].o == OP_READ_BYTE) rd(REG_RDATA, st, rr);
      `CHK(st & rows[i].m, rows[i].x)
    end
    vpp_bad <= 1'b0;
    wr(8'h40, 32'h1, rr);
    `CHK(rr, RESP_SLVERR)
    rd(8'h40, st, rr);
    `CHK({rr, st}, {RESP_SLVERR, 32'h0})
    // Lane 0 off leaves a register alone; own registers read back
    s_axi_wstrb <= 4'he;
    wr(REG_DATA, 32'h0000_00aa, rr);
    s_axi_wstrb <= 4'hf;
    rd(REG_DATA, st, rr);
    `CHK(st, 32'h0000_0000)
    rd(REG_CTRL, st, rr);
    `CHK(st, 32'h0000_0000)
    op(OP_READ_ARRAY, 20'h0_0123, st);
    `CHK({st[ST_DONE], st[ST_BUSY]}, 2'b10)
    rd(REG_ADDR, st, rr);
    `CHK(st, 32'h0000_0123)
    rd(REG_CMD, st, rr);
    `CHK(st, {29'h0, OP_READ_ARRAY})
    // A command while busy is dropped; ready pin low meanwhile
    busy_cyc <= 16'h012c;
    wr(REG_ADDR, 32'h0005_0000, rr);
    wr(REG_DATA, 32'h0, rr);
    wr(REG_CMD, {29'h0, OP_ERASE}, rr);
    rd(REG_STATUS, st, rr);
    `CHK(st[ST_BUSY], 1'b1)
    wr(REG_CMD, {29'h0, OP_PROGRAM}, rr);
    do
    begin
      rd(REG_STATUS, st, rr);
      seen = seen | !st[ST_READY_PIN];
    end
    while (st[ST_BUSY]);
    `CHK(seen, 1'b1)
    op(OP_READ_BYTE, 20'h5_0000, st);
    rd(REG_RDATA, st, rr);
    `CHK(st[7:0], 8'hff)
    // Power-down request aborts and clears the flash status
    vpp_bad <= 1'b1;
    op(OP_PROGRAM, 20'h4_0001, st);
    vpp_bad <= 1'b0;
    wr(REG_CMD, {29'h0, OP_ERASE}, rr);
    wr(REG_CTRL, 32'h1, rr);
    rd(REG_STATUS, st, rr);
    `CHK({st[ST_ABORT], st[ST_BUSY], reset_powerdown_n}, 3'b100)
    wr(REG_CTRL, 32'h0, rr);
    wait_up();
    op(OP_PROGRAM, 20'h4_0002, st);
    `CHK(st[7:0], 8'h80)
    // Loss of system power holds the flash in reset
    system_power_ok <= 1'b0;
    repeat (8) @(posedge aclk);
    `CHK(reset_powerdown_n, 1'b0)
    system_power_ok <= 1'b1;
    wait_up();
    // Reset in mid-operation: pin low, strobes released, sequencer idle after
    wr(REG_CMD, {29'h0, OP_ERASE}, rr);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    `CHK({reset_powerdown_n, flash_we_n, flash_ce_n, s_axi_bvalid}, 4'b0110)
    aresetn <= 1'b1;
    wait_up();
    `CHK({st[ST_DONE], st[ST_ABORT], st[ST_BUSY]}, 3'b000)
    summarize();
  end
endmodule // fpls_host_tb
